// ===== shared/dcio_pkg.sv
/*
  Shared constants for the dual-channel I/O mode multiplexer: mode
  encodings, pin positions per mode, reset-output sequencing states and
  timing. Assumes a single 40 MHz reference clock.
*/
package dcio_pkg;

  // ****************************************************************
  // Channels and pin groups
  // ****************************************************************
  localparam int NUM_CH = 2;
  localparam int CH_A = 0;
  localparam int CH_B = 1;
  localparam int DATA_W = 8;
  localparam int CTL_W = 4;
  localparam int MCU_AD_W = 16;
  localparam int SE_GPIO_W = 8;
  localparam int MCU_GPIO_W = 2;

  // ****************************************************************
  // Channel modes (Gray order along the configuration list)
  // ****************************************************************
  typedef enum logic [2:0] {
    DCIO_UART          = 3'h0,
    DCIO_FIFO          = 3'h1,
    DCIO_CPU_FIFO      = 3'h3,
    DCIO_BITBANG       = 3'h2,
    DCIO_SYNC_BITBANG  = 3'h6,
    DCIO_SERIAL_ENGINE = 3'h7,
    DCIO_MCU_BUS       = 3'h5,
    DCIO_ISO_SERIAL    = 3'h4
  } dcio_mode_t;

  // ****************************************************************
  // Reset output sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    DCIO_RS_WAIT  = 2'h0,
    DCIO_RS_HOLD  = 2'h1,
    DCIO_RS_DRIVE = 2'h3
  } dcio_rst_state_t;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_KHZ = 40000;
  localparam int RST_HOLD_US = 2000;
  localparam int RST_HOLD_CYC = (RST_HOLD_US * CLK_KHZ + 999) / 1000;

  // ****************************************************************
  // Data pin positions
  // ****************************************************************
  localparam int U_TXD = 0;
  localparam int U_RXD = 1;
  localparam int U_RTS = 2;
  localparam int U_CTS = 3;
  localparam int U_DTR = 4;
  localparam int U_DSR = 5;
  localparam int U_DCD = 6;
  localparam int U_RI = 7;
  localparam int SE_CLK = 0;
  localparam int SE_DOUT = 1;
  localparam int SE_DIN = 2;
  localparam int SE_SEL = 3;
  localparam int SE_GPL_LSB = 4;
  localparam int SE_GP_NIB = 4;
  localparam int ISO_DIN = 0;
  localparam int ISO_CLK = 1;
  localparam int ISO_DOUT = 2;
  localparam int ISO_CTS = 3;

  // ****************************************************************
  // Control pin positions
  // ****************************************************************
  localparam int C_UART_TRANSMIT_DRIVE_ENABLE = 0;
  localparam int C_UART_SLEEP = 1;
  localparam int C_UART_RXIND = 2;
  localparam int C_UART_TXIND = 3;
  localparam int C_FIFO_RXF = 0;
  localparam int C_FIFO_TXE = 1;
  localparam int C_CPU_CS = 0;
  localparam int C_CPU_A0 = 1;
  localparam int C_RD = 2;
  localparam int C_WR = 3;
  localparam int C_BB_WR_LO = 0;
  localparam int C_BB_RD_LO = 1;
  localparam int C_BB_WR_HI = 2;
  localparam int C_BB_RD_HI = 3;
  localparam int C_MCU_IO_READY = 2;
  localparam int C_MCU_OSC = 3;
  localparam int C_MCU_CS = 0;
  localparam int C_MCU_ALE = 1;

endpackage

// ===== design/dcio_rst_seq.sv
/*
  Reset-output sequencer and power-enable output. Assumes supply_ok is
  already synchronous to ref_clk and means supply above threshold with
  the internal clock running.
*/
`timescale 1ns/10ps
module dcio_rst_seq #(
  parameter int HOLD_CYC = dcio_pkg::RST_HOLD_CYC
) (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Async reset, low active
  input wire logic clk_en, // Freezes state when low
  input wire logic supply_ok, // Supply good and clock running
  input wire logic reset_input_n, // External chip reset, low active
  input wire logic usb_configured, // USB configuration complete
  input wire logic usb_suspend, // USB in suspend
  output logic reset_output, // Reset output level
  output logic reset_output_oe, // Reset output driven
  output logic power_enable_n // Power enable, low active
);
  import dcio_pkg::*;

  localparam int CW = $clog2(HOLD_CYC + 1);
  localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYC - 1);

  dcio_rst_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic pwr_n_q, pwr_n_d;

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  // No USB bus-reset input exists here, so a bus reset cannot disturb it
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      DCIO_RS_WAIT: begin
        cnt_d = '0;
        if (supply_ok && reset_input_n) begin
          state_d = DCIO_RS_HOLD;
        end
      end
      DCIO_RS_HOLD: begin
        cnt_d = cnt_q + CW'(1);
        if (cnt_q == HOLD_LAST) begin
          state_d = DCIO_RS_DRIVE;
        end
      end
      DCIO_RS_DRIVE: ;
      default: state_d = DCIO_RS_WAIT;
    endcase
    if (!reset_input_n || !supply_ok) begin
      state_d = DCIO_RS_WAIT;
      cnt_d = '0;
    end
  end

  // Suspend wins over configured so power drops during suspend
  assign pwr_n_d = usb_suspend ? 1'b1 : (usb_configured ? 1'b0 : pwr_n_q);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DCIO_RS_WAIT;
      cnt_q <= '0;
      pwr_n_q <= 1'b1;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pwr_n_q <= pwr_n_d;
    end
  end

  assign reset_output = 1'b1;
  assign reset_output_oe = (state_q == DCIO_RS_DRIVE);
  assign power_enable_n = pwr_n_q;

endmodule

// ===== design/dcio_mux.sv
/*
  Dual-channel I/O function multiplexer: maps the eight data pins and four
  control pins of channels A and B onto the function signals of each chip
  mode, and hosts the reset-output and power-enable sequencer. Assumes all
  pin inputs are synchronous to ref_clk and that the surrounding pad logic
  resolves each pin from its output and output enable.
*/
`timescale 1ns/10ps

module dcio_mux #(
  parameter int RST_HOLD = dcio_pkg::RST_HOLD_CYC
) (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Async reset, low active
  input wire logic clk_en, // Freezes state when low
  input wire dcio_pkg::dcio_mode_t [1:0] chan_mode, // Mode per channel
  input wire logic [1:0] bb_base_uart, // Bit-bang main mode is UART
  input wire logic [1:0][7:0] data_pin_in, // Data pin levels
  output logic [1:0][7:0] data_pin_out, // Data pin drive values
  output logic [1:0][7:0] data_pin_oe, // Data pin drive enables
  input wire logic [1:0][3:0] ctl_pin_in, // Control pin levels
  output logic [1:0][3:0] ctl_pin_out, // Control pin drive values
  output logic [1:0][3:0] ctl_pin_oe, // Control pin drive enables
  input wire logic [1:0] send_now_wakeup_pin_n, // Send-now pins
  output logic [1:0] send_now_wakeup_n, // Send-now to core
  input wire logic [1:0] uart_txd, // Transmit data
  input wire logic [1:0] uart_rts_n, // Request to send
  input wire logic [1:0] uart_dtr_n, // Terminal ready
  input wire logic [1:0] uart_tx_drive_en, // Transmit drive enable
  input wire logic [1:0] uart_sleep_n, // Sleep
  input wire logic [1:0] uart_rx_ind_n, // Receive indicator
  input wire logic [1:0] uart_tx_ind_n, // Transmit indicator
  output logic [1:0] uart_rxd, // Receive data
  output logic [1:0] uart_cts_n, // Clear to send
  output logic [1:0] uart_dsr_n, // Set ready
  output logic [1:0] uart_dcd_n, // Carrier detect
  output logic [1:0] uart_ri_n, // Ring indicator
  input wire logic [1:0][7:0] fifo_wdata, // FIFO data to pins
  input wire logic [1:0] fifo_drive, // FIFO drives the bus
  input wire logic [1:0] rx_full_flag_n, // Data ready to read
  input wire logic [1:0] tx_space_flag_n, // Room to write
  output logic [1:0][7:0] par_rdata, // Parallel data from pins
  output logic [1:0] fifo_rd_n, // Read strobe from pins
  output logic [1:0] fifo_wr_n, // Write strobe from pins
  output logic [1:0] cpu_cs_n, // CPU FIFO chip select
  output logic [1:0] address_bit_zero, // CPU FIFO address bit
  input wire logic [1:0][7:0] bb_wdata, // Bit-bang output data
  input wire logic [1:0][7:0] bb_dir, // Bit-bang bit is output
  input wire logic [1:0] bb_rd_strobe_n, // Bit-bang read strobe
  input wire logic [1:0] bb_wr_strobe_n, // Bit-bang write strobe
  input wire logic serial_clock_out, // Serial engine clock
  input wire logic serial_data_out, // Serial engine data out
  input wire logic se_select_n, // Serial engine select
  output logic serial_data_in, // Serial engine data in
  input wire logic [7:0] se_gpio_out, // Gp bits, low nibble low_gp_io_bit
  input wire logic [7:0] se_gpio_oe, // Gp bit drive enables
  output logic [7:0] se_gpio_in, // Gp bit levels
  input wire logic [15:0] mux_addr_data_out, // MCU address/data out
  input wire logic mux_addr_data_oe, // MCU bus driven
  output logic [15:0] mux_addr_data_in, // MCU address/data in
  input wire logic mcu_cs_n, // MCU chip select
  input wire logic mcu_ale, // MCU address latch enable
  input wire logic mcu_rd_n, // MCU read strobe
  input wire logic mcu_wr_n, // MCU write strobe
  input wire logic [1:0] mcu_gpio_out, // MCU gp bits out
  input wire logic [1:0] mcu_gpio_oe, // MCU gp bit enables
  output logic [1:0] mcu_gpio_in, // MCU gp bits in
  output logic io_ready, // MCU ready from pin
  input wire logic oscillator_out, // MCU oscillator
  input wire logic iso_serial_clock, // Isolated serial clock
  input wire logic iso_data_out, // Isolated data out
  output logic iso_data_in, // Isolated data in
  output logic iso_clear_to_send, // Peripheral ready for next bit
  output logic iso_share, // Both channels on isolated link
  input wire logic supply_ok, // Supply good, clock running
  input wire logic reset_input_n, // External reset, low active
  input wire logic usb_configured, // USB configured
  input wire logic usb_suspend, // USB suspend
  output logic reset_output, // Reset output level
  output logic reset_output_oe, // Reset output driven
  output logic power_enable_n // Power enable, low active
);
  import dcio_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic send_now_off(input dcio_mode_t m);
    send_now_off = (m == DCIO_CPU_FIFO) || (m == DCIO_SERIAL_ENGINE) ||
                   (m == DCIO_MCU_BUS) || (m == DCIO_ISO_SERIAL);
  endfunction

  logic [1:0][7:0] din_q;
  logic [1:0][3:0] cin_q;
  logic [1:0] sn_q;
  dcio_mode_t mode_a_w, mode_b_w;

  assign mode_a_w = chan_mode[CH_A];
  // MCU bus spans both channels, so channel A's choice owns B as well
  assign mode_b_w = (mode_a_w == DCIO_MCU_BUS) ? DCIO_MCU_BUS : chan_mode[CH_B];
  assign iso_share = (mode_a_w == DCIO_ISO_SERIAL) && (mode_b_w == DCIO_ISO_SERIAL);

  // ****************************************************************
  // Per-channel output selection
  // ****************************************************************
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    dcio_mode_t mode_w;
    logic [7:0] dout_c, doe_c, dout_q, doe_q;
    logic [3:0] cout_c, coe_c, cout_q, coe_q;
    logic sn_d;

    assign mode_w = (ch == CH_A) ? mode_a_w : mode_b_w;

    always_comb begin
      dout_c = '0;
      doe_c = '0;
      cout_c = '0;
      coe_c = '0;
      case (mode_w)
        DCIO_UART: begin
          dout_c[U_TXD] = uart_txd[ch];
          dout_c[U_RTS] = uart_rts_n[ch];
          dout_c[U_DTR] = uart_dtr_n[ch];
          doe_c[U_TXD] = 1'b1;
          doe_c[U_RTS] = 1'b1;
          doe_c[U_DTR] = 1'b1;
          cout_c[C_UART_TRANSMIT_DRIVE_ENABLE] = uart_tx_drive_en[ch];
          cout_c[C_UART_SLEEP] = uart_sleep_n[ch];
          cout_c[C_UART_RXIND] = uart_rx_ind_n[ch];
          cout_c[C_UART_TXIND] = uart_tx_ind_n[ch];
          coe_c = '1;
        end
        DCIO_FIFO: begin
          dout_c = fifo_wdata[ch];
          doe_c = {DATA_W{fifo_drive[ch]}};
          cout_c[C_FIFO_RXF] = rx_full_flag_n[ch];
          cout_c[C_FIFO_TXE] = tx_space_flag_n[ch];
          coe_c[C_FIFO_RXF] = 1'b1;
          coe_c[C_FIFO_TXE] = 1'b1;
        end
        DCIO_CPU_FIFO: begin
          // All four control pins are inputs from the CPU
          dout_c = fifo_wdata[ch];
          doe_c = {DATA_W{fifo_drive[ch]}};
        end
        DCIO_BITBANG, DCIO_SYNC_BITBANG: begin
          dout_c = bb_wdata[ch];
          doe_c = bb_dir[ch];
          if (bb_base_uart[ch]) begin
            cout_c[C_BB_WR_HI] = bb_wr_strobe_n[ch];
            cout_c[C_BB_RD_HI] = bb_rd_strobe_n[ch];
            coe_c[C_BB_WR_HI] = 1'b1;
            coe_c[C_BB_RD_HI] = 1'b1;
          end else begin
            cout_c[C_BB_WR_LO] = bb_wr_strobe_n[ch];
            cout_c[C_BB_RD_LO] = bb_rd_strobe_n[ch];
            coe_c[C_BB_WR_LO] = 1'b1;
            coe_c[C_BB_RD_LO] = 1'b1;
          end
        end
        DCIO_SERIAL_ENGINE: begin
          // Channel B leaves every pin floating in this mode
          if (ch == CH_A) begin
            dout_c[SE_CLK] = serial_clock_out;
            dout_c[SE_DOUT] = serial_data_out;
            dout_c[SE_SEL] = se_select_n;
            doe_c[SE_CLK] = 1'b1;
            doe_c[SE_DOUT] = 1'b1;
            doe_c[SE_SEL] = 1'b1;
            dout_c[SE_GPL_LSB +: SE_GP_NIB] = se_gpio_out[SE_GP_NIB-1:0];
            doe_c[SE_GPL_LSB +: SE_GP_NIB] = se_gpio_oe[SE_GP_NIB-1:0];
            cout_c = se_gpio_out[SE_GPIO_W-1:SE_GP_NIB];
            coe_c = se_gpio_oe[SE_GPIO_W-1:SE_GP_NIB];
          end
        end
        DCIO_MCU_BUS: begin
          if (ch == CH_A) begin
            dout_c = mux_addr_data_out[DATA_W-1:0];
            doe_c = {DATA_W{mux_addr_data_oe}};
            cout_c[MCU_GPIO_W-1:0] = mcu_gpio_out;
            coe_c[MCU_GPIO_W-1:0] = mcu_gpio_oe;
            cout_c[C_MCU_OSC] = oscillator_out;
            coe_c[C_MCU_OSC] = 1'b1;
          end else begin
            dout_c = mux_addr_data_out[MCU_AD_W-1:DATA_W];
            doe_c = {DATA_W{mux_addr_data_oe}};
            cout_c[C_MCU_CS] = mcu_cs_n;
            cout_c[C_MCU_ALE] = mcu_ale;
            cout_c[C_RD] = mcu_rd_n;
            cout_c[C_WR] = mcu_wr_n;
            coe_c = '1;
          end
        end
        DCIO_ISO_SERIAL: begin
          // The link lives on channel B pins only
          if (ch == CH_B) begin
            dout_c[ISO_CLK] = iso_serial_clock;
            dout_c[ISO_DOUT] = iso_data_out;
            doe_c[ISO_CLK] = 1'b1;
            doe_c[ISO_DOUT] = 1'b1;
          end
        end
        default: ;
      endcase
    end

    assign sn_d = send_now_wakeup_pin_n[ch] | send_now_off(mode_w);

    // One register stage for all twelve pins, so a mode change lands at once
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        dout_q <= '0;
        doe_q <= '0;
        cout_q <= '0;
        coe_q <= '0;
      end else if (clk_en) begin
        dout_q <= dout_c;
        doe_q <= doe_c;
        cout_q <= cout_c;
        coe_q <= coe_c;
      end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        din_q[ch] <= '0;
        cin_q[ch] <= '0;
        sn_q[ch] <= 1'b1;
      end else if (clk_en) begin
        din_q[ch] <= data_pin_in[ch];
        cin_q[ch] <= ctl_pin_in[ch];
        sn_q[ch] <= sn_d;
      end
    end

    assign data_pin_out[ch] = dout_q;
    assign data_pin_oe[ch] = doe_q;
    assign ctl_pin_out[ch] = cout_q;
    assign ctl_pin_oe[ch] = coe_q;
  end

  // ****************************************************************
  // Pin inputs toward the core (registered)
  // ****************************************************************
  assign send_now_wakeup_n = sn_q;
  assign par_rdata = din_q;
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_in
    assign uart_rxd[ch] = din_q[ch][U_RXD];
    assign uart_cts_n[ch] = din_q[ch][U_CTS];
    assign uart_dsr_n[ch] = din_q[ch][U_DSR];
    assign uart_dcd_n[ch] = din_q[ch][U_DCD];
    assign uart_ri_n[ch] = din_q[ch][U_RI];
    assign cpu_cs_n[ch] = cin_q[ch][C_CPU_CS];
    assign address_bit_zero[ch] = cin_q[ch][C_CPU_A0];
    assign fifo_rd_n[ch] = cin_q[ch][C_RD];
    assign fifo_wr_n[ch] = cin_q[ch][C_WR];
  end
  assign serial_data_in = din_q[CH_A][SE_DIN];
  assign se_gpio_in = {cin_q[CH_A], din_q[CH_A][SE_GPL_LSB +: SE_GP_NIB]};
  assign mux_addr_data_in = {din_q[CH_B], din_q[CH_A]};
  assign mcu_gpio_in = cin_q[CH_A][MCU_GPIO_W-1:0];
  assign io_ready = cin_q[CH_A][C_MCU_IO_READY];
  // Clear-to-send is passed on untouched; the core waits on it for pacing
  assign iso_data_in = din_q[CH_B][ISO_DIN];
  assign iso_clear_to_send = din_q[CH_B][ISO_CTS];

  // ****************************************************************
  // Reset output and power enable
  // ****************************************************************
  dcio_rst_seq #(
    .HOLD_CYC(RST_HOLD)
  ) u_rst_seq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .supply_ok(supply_ok),
    .reset_input_n(reset_input_n),
    .usb_configured(usb_configured),
    .usb_suspend(usb_suspend),
    .reset_output(reset_output),
    .reset_output_oe(reset_output_oe),
    .power_enable_n(power_enable_n)
  );

endmodule

// ===== verification/dcio_mux_chk.sv
/*
  Concurrent checks on the multiplexer ports.
  Assumes one clock domain; bound from the testbench.
*/
`timescale 1ns/10ps
module dcio_mux_chk #(
  parameter int RST_HOLD = 8
) (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset, low active
  input wire logic clk_en, // Run enable
  input wire dcio_pkg::dcio_mode_t [1:0] chan_mode, // Modes
  input wire logic [1:0][7:0] data_pin_out, // Data drive
  input wire logic [1:0][7:0] data_pin_oe, // Data enables
  input wire logic [1:0][3:0] ctl_pin_oe, // Control enables
  input wire logic [1:0] send_now_wakeup_n, // Send-now
  input wire logic [1:0] uart_txd, // Transmit data
  input wire logic [15:0] mux_addr_data_out, // Bus out
  input wire logic mux_addr_data_oe, // Bus driven
  input wire logic iso_share, // Shared link
  input wire logic supply_ok, // Supply good
  input wire logic reset_input_n, // External reset
  input wire logic usb_configured, // Configured
  input wire logic usb_suspend, // Suspend
  input wire logic reset_output, // Reset level
  input wire logic reset_output_oe, // Reset driven
  input wire logic power_enable_n // Power enable
);
  import dcio_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // Settle counter for the reset output
  // ****************************************************************
  int cnt_q;
  int cnt_d;
  wire logic arm = supply_ok && reset_input_n;
  assign cnt_d = !arm ? 0 : (cnt_q > RST_HOLD) ? cnt_q : cnt_q + 1;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 0;
    else if (clk_en) cnt_q <= cnt_d;
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  chk_rst_hold: assert property (reset_output_oe == (cnt_q > RST_HOLD) && reset_output)
    else $error("reset output timing wrong");
  chk_rst_float: assert property (clk_en && !reset_input_n |=> !reset_output_oe)
    else $error("reset output still driven");
  chk_pwr_off: assert property (clk_en && usb_suspend |=> power_enable_n)
    else $error("power enable low in suspend");
  chk_pwr_on: assert property (clk_en && usb_configured && !usb_suspend |=> !power_enable_n)
    else $error("power enable not low");
  // Sampled rst_n keeps the release edge out, where the pin flops still reset
  chk_uart_map: assert property (clk_en && rst_n && chan_mode[0] == DCIO_UART |=>
    data_pin_out[0][0] == $past(uart_txd[0]) && data_pin_oe[0] == 8'h15)
    else $error("uart pin map wrong");
  chk_se_b_off: assert property (clk_en && chan_mode[1] == DCIO_SERIAL_ENGINE &&
    chan_mode[0] != DCIO_MCU_BUS |=> data_pin_oe[1] == 8'h00 && ctl_pin_oe[1] == 4'h0)
    else $error("channel B driven in serial engine mode");
  chk_snw_off: assert property (clk_en && chan_mode[0] inside
    {DCIO_CPU_FIFO, DCIO_SERIAL_ENGINE, DCIO_MCU_BUS} |=> send_now_wakeup_n[0])
    else $error("send-now active in a mode without it");
  chk_mcu_bus: assert property (clk_en && chan_mode[0] == DCIO_MCU_BUS && mux_addr_data_oe |=>
    data_pin_out == $past(mux_addr_data_out) && data_pin_oe == 16'hFFFF)
    else $error("bus address/data map wrong");
  chk_iso_share: assert property (iso_share ==
    (chan_mode[0] == DCIO_ISO_SERIAL && chan_mode[1] == DCIO_ISO_SERIAL))
    else $error("shared link flag wrong");
endmodule

// ===== verification/dcio_periph.sv
/*
  Far-side peripheral: resolves each pin from device and peripheral drive.
  Assumes the testbench sets the peripheral drive.
*/
`timescale 1ns/10ps
module dcio_periph (
  input wire logic [1:0][7:0] dev_d, // Device data drive
  input wire logic [1:0][7:0] dev_d_oe, // Device data enable
  input wire logic [1:0][3:0] dev_c, // Device control drive
  input wire logic [1:0][3:0] dev_c_oe, // Device control enable
  input wire logic [1:0][7:0] per_d, // Peripheral data drive
  input wire logic [1:0][7:0] per_d_oe, // Peripheral data enable
  input wire logic [1:0][3:0] per_c, // Peripheral control drive
  input wire logic [1:0][3:0] per_c_oe, // Peripheral control enable
  output logic [1:0][7:0] d_pin, // Data pins
  output logic [1:0][3:0] c_pin // Control pins
);
  // Undriven pins rest high on the pull-ups; peripheral paces via its lines
  assign d_pin = (dev_d & dev_d_oe) | (per_d & per_d_oe & ~dev_d_oe) | ~(dev_d_oe | per_d_oe);
  assign c_pin = (dev_c & dev_c_oe) | (per_c & per_c_oe & ~dev_c_oe) | ~(dev_c_oe | per_c_oe);
endmodule

// ===== verification/dcio_mux_tb.sv
/*
  Testbench for the multiplexer: mode maps, reset output, power enable.
  Assumes the peripheral model and the checker compile first.
*/
`timescale 1ns/10ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin failures++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, a); end end
module dcio_mux_tb;
  import dcio_pkg::*;
  localparam int HOLD = 8;
  int failures = 0, num_checks = 0, b;
  logic e;
  logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
  dcio_mode_t [1:0] chan_mode;
  logic [1:0] bb_base_uart = '0, send_now_wakeup_pin_n = '1, uart_txd = '0, uart_rts_n = '0, uart_dtr_n = '0;
  logic [1:0] uart_tx_drive_en = '0, uart_sleep_n = '0, uart_rx_ind_n = '0, uart_tx_ind_n = '0;
  logic [1:0] fifo_drive = '0, rx_full_flag_n = '0, tx_space_flag_n = '0, bb_rd_strobe_n = '0;
  logic [1:0] bb_wr_strobe_n = '0, mcu_gpio_out = '0, mcu_gpio_oe = '0;
  logic [1:0][7:0] fifo_wdata = '0, bb_wdata = '0, bb_dir = '0, per_d = '0, per_d_oe = '0;
  logic [1:0][3:0] per_c = '0, per_c_oe = '0;
  logic serial_clock_out = 1'b0, serial_data_out = 1'b0, se_select_n = 1'b0, mux_addr_data_oe = 1'b0;
  logic mcu_cs_n = 1'b0, mcu_ale = 1'b0, mcu_rd_n = 1'b0, mcu_wr_n = 1'b0, oscillator_out = 1'b0;
  logic iso_serial_clock = 1'b0, iso_data_out = 1'b0, supply_ok = 1'b0, reset_input_n = 1'b1;
  logic usb_configured = 1'b0, usb_suspend = 1'b0;
  logic [7:0] se_gpio_out = '0, se_gpio_oe = '0;
  logic [15:0] mux_addr_data_out = '0;
  wire logic [1:0][7:0] data_pin_in, data_pin_out, data_pin_oe, par_rdata;
  wire logic [1:0][3:0] ctl_pin_in, ctl_pin_out, ctl_pin_oe;
  wire logic [1:0] send_now_wakeup_n, uart_rxd, uart_cts_n, uart_dsr_n, uart_dcd_n, uart_ri_n;
  wire logic [1:0] fifo_rd_n, fifo_wr_n, cpu_cs_n, address_bit_zero, mcu_gpio_in;
  wire logic serial_data_in, io_ready, iso_data_in, iso_clear_to_send, iso_share;
  wire logic reset_output, reset_output_oe, power_enable_n;
  wire logic [7:0] se_gpio_in;
  wire logic [15:0] mux_addr_data_in;
  dcio_mux #(.RST_HOLD(HOLD)) u_dut (.*);
  dcio_periph u_per (.dev_d(data_pin_out), .dev_d_oe(data_pin_oe), .dev_c(ctl_pin_out), .dev_c_oe(ctl_pin_oe),
    .per_d(per_d), .per_d_oe(per_d_oe), .per_c(per_c), .per_c_oe(per_c_oe), .d_pin(data_pin_in), .c_pin(ctl_pin_in));
  initial begin
    chan_mode[0] = DCIO_UART;
    chan_mode[1] = DCIO_UART;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic mode(input dcio_mode_t a, input dcio_mode_t c);
    @(posedge ref_clk);
    chan_mode[0] <= a;
    chan_mode[1] <= c;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #(25 * 3000);
    failures++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    supply_ok <= 1'b1;
    tk(HOLD);
    `CHK("rst oe early", 1'b0, reset_output_oe)
    tk(0);
    `CHK("rst oe", 1'b1, reset_output_oe)
    @(posedge ref_clk);
    reset_input_n <= 1'b0;
    usb_configured <= 1'b1;
    tk(1);
    `CHK("rst float", 1'b0, reset_output_oe)
    `CHK("pwr on", 1'b0, power_enable_n)
    @(posedge ref_clk);
    reset_input_n <= 1'b1;
    usb_suspend <= 1'b1;
    tk(1);
    `CHK("pwr suspend", 1'b1, power_enable_n)
    tk(HOLD);
    `CHK("rst again", 1'b1, reset_output_oe)
    mode(DCIO_UART, DCIO_UART);
    {uart_txd, uart_rts_n, uart_dtr_n, uart_tx_drive_en} <= 8'hCF;
    {uart_sleep_n, uart_rx_ind_n, uart_tx_ind_n} <= 6'h0C;
    per_d <= 16'h4A4A;
    per_d_oe <= '1;
    tk(2);
    for (b = 0; b < 2; b++) begin
      `CHK("uart out", 8'h11, data_pin_out[b] & data_pin_oe[b])
      `CHK("uart oe", 12'h15F, {data_pin_oe[b], ctl_pin_oe[b]})
      `CHK("uart ctl", 4'h5, ctl_pin_out[b])
      `CHK("uart in", 5'h0B, {uart_ri_n[b], uart_dcd_n[b], uart_dsr_n[b], uart_cts_n[b], uart_rxd[b]})
    end
    mode(DCIO_CPU_FIFO, DCIO_FIFO);
    fifo_wdata <= 16'h3CC3;
    {fifo_drive, rx_full_flag_n, tx_space_flag_n} <= 6'h39;
    per_c <= 8'h66;
    per_c_oe <= '1;
    tk(2);
    `CHK("fifo data", 32'h3CC3FFFF, {data_pin_out, data_pin_oe})
    `CHK("cpu ctl", 4'h6, {fifo_wr_n[0], fifo_rd_n[0], address_bit_zero[0], cpu_cs_n[0]})
    `CHK("fifo flags", 2'h1, ctl_pin_out[1][1:0])
    @(posedge ref_clk);
    fifo_drive <= 2'b00;
    tk(2);
    `CHK("par in", 16'h4A4A, par_rdata)
    for (b = 0; b < 2; b++) begin
      mode(DCIO_BITBANG, DCIO_SYNC_BITBANG);
      bb_base_uart <= {2{b[0]}};
      {bb_wdata, bb_dir} <= 32'h5AA5FFFF;
      {bb_wr_strobe_n, bb_rd_strobe_n} <= 4'h3;
      tk(2);
      `CHK("bb data", 16'h5AA5, data_pin_out)
      `CHK("bb oe", {2{(b ? 4'hC : 4'h3)}}, ctl_pin_oe)
      `CHK("bb strobe", {2{(b ? 4'h8 : 4'h2)}}, ctl_pin_out & ctl_pin_oe)
    end
    mode(DCIO_SERIAL_ENGINE, DCIO_SERIAL_ENGINE);
    {serial_clock_out, serial_data_out, se_select_n} <= 3'h6;
    {se_gpio_out, se_gpio_oe} <= 16'hA6FF;
    per_d <= '1;
    tk(2);
    `CHK("se data", 8'h63, data_pin_out[0] & 8'hFB)
    `CHK("se ctl", 5'h15, {ctl_pin_out[0], serial_data_in})
    `CHK("se b off", 12'h0, {data_pin_oe[1], ctl_pin_oe[1]})
    `CHK("se gp in", 8'hA6, se_gpio_in)
    mode(DCIO_MCU_BUS, DCIO_UART);
    {mux_addr_data_out, mux_addr_data_oe} <= 17'h02469;
    {mcu_wr_n, mcu_rd_n, mcu_ale, mcu_cs_n, mcu_gpio_out, mcu_gpio_oe, oscillator_out} <= 9'h0D7;
    tk(2);
    `CHK("mcu ad", 16'h1234, data_pin_out)
    `CHK("mcu b ctl", 4'h6, ctl_pin_out[1])
    `CHK("mcu a ctl", 5'h15, {ctl_pin_out[0] & 4'hB, io_ready})
    `CHK("mcu gp in", 2'h2, mcu_gpio_in)
    @(posedge ref_clk);
    mux_addr_data_oe <= 1'b0;
    per_d <= 16'hBEEF;
    tk(2);
    `CHK("mcu in", 16'hBEEF, mux_addr_data_in)
    mode(DCIO_ISO_SERIAL, DCIO_ISO_SERIAL);
    {iso_serial_clock, iso_data_out} <= 2'b10;
    per_d <= 16'h0900;
    tk(2);
    `CHK("iso in", 3'h7, {iso_share, iso_data_in, iso_clear_to_send})
    `CHK("iso out", 2'h1, data_pin_out[1][2:1])
    // Clock enable low must hold pins and mirrors
    @(posedge ref_clk);
    clk_en <= 1'b0;
    iso_serial_clock <= 1'b0;
    per_d <= '0;
    tk(2);
    `CHK("freeze", 3'h5, {iso_data_in, data_pin_out[1][2:1]})
    @(posedge ref_clk);
    clk_en <= 1'b1;
    for (b = 0; b < 8; b++) begin
      mode(dcio_mode_t'(b), dcio_mode_t'(b));
      send_now_wakeup_pin_n <= 2'b00;
      tk(2);
      e = dcio_mode_t'(b) inside {DCIO_CPU_FIFO, DCIO_SERIAL_ENGINE, DCIO_MCU_BUS, DCIO_ISO_SERIAL};
      `CHK("send now", e, send_now_wakeup_n[0])
    end
    final_report();
  end
endmodule
bind dcio_mux dcio_mux_chk #(.RST_HOLD(RST_HOLD)) u_chk (.*);
